// ### design/scpc_top.sv
// Clock source control, system clock prescaler and RC trim register
`timescale 1ns/1ps
module scpc_top #(
	parameter int FAST_CYCLES = scpc_pkg::FAST_CYCLES,
	parameter int SLOW_CYCLES = scpc_pkg::SLOW_CYCLES
) (
	// Clock, reset and clock enable
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	// Fuses and factory calibration byte
	input  wire scpc_pkg::scpc_fuse_type fuses,
	// Register port
	input  wire scpc_pkg::scpc_bus_type  bus,
	output logic [7:0]                   rdata,
	// Wake-up from sleep
	input  wire logic                    wake_req,
	output logic                         wake_done,
	// Core reset and divided clock
	output logic                         core_reset_n,
	output logic                         sys_clk_enable,
	// Clock output pin and its normal port function
	input  wire logic                    port_out,
	input  wire logic                    port_oe,
	output logic                         clock_output_pin,
	output logic                         clock_output_pin_oe,
	// Oscillator steering
	output logic                         sys_source_external,
	output logic                         timer_osc_crystal_enable,
	output logic                         timer_osc_ext_clock_accept,
	output logic                         trim_range_bit,
	output logic [6:0]                   trim_fine_field
);
	// Reset sequence states
	typedef enum logic [3:0] {
		SEQ_SYNC  = 4'b0001,
		SEQ_LOAD  = 4'b0010,
		SEQ_DELAY = 4'b0100,
		SEQ_RUN   = 4'b1000
	} scpc_seq_type;

	scpc_pkg::scpc_fuse_type fuse_meta;
	scpc_pkg::scpc_fuse_type fuse_sync;
	scpc_seq_type            seq;
	logic [1:0]              sync_count;
	logic                    delay_done;
	logic [7:0]              rc_oscillator_trim;
	logic [3:0]              prescale_select_field;
	logic                    prescale_change_enable;
	logic [2:0]              pce_count;
	logic [7:0]              async_timer_status_reg;
	logic                    div_tick;
	logic                    div_level;
	logic [3:0]              div_active;
	logic                    rc_selected;
	logic                    wr_trim;
	logic                    wr_presc;
	logic                    wr_async;
	logic                    pce_open_write;
	logic                    field_write;
	logic                    pce_arm;

	// Fuse and calibration inputs pass two flip-flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fuse_meta <= '0;
			fuse_sync <= '0;
		end else if (ce) begin
			fuse_meta <= fuses;
			fuse_sync <= fuse_meta;
		end
	end

	// Reset sequence: settle fuses, load registers, count delay
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq        <= SEQ_SYNC;
			sync_count <= 2'h0;
		end else if (ce) begin
			unique case (seq)
				SEQ_SYNC: begin
					sync_count <= 2'(sync_count + 2'h1);
					if (sync_count == scpc_pkg::SYNC_WAIT) seq <= SEQ_LOAD;
				end
				SEQ_LOAD: seq <= SEQ_DELAY;
				SEQ_DELAY: begin
					if (delay_done) seq <= SEQ_RUN;
				end
				SEQ_RUN: seq <= SEQ_RUN;
				default: seq <= SEQ_SYNC;
			endcase
		end
	end

	assign core_reset_n = (seq == SEQ_RUN);

	// Reset and wake-up delay counters
	scpc_startup #(
		.FAST_CYCLES (FAST_CYCLES),
		.SLOW_CYCLES (SLOW_CYCLES)
	) u_startup (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.start     (seq == SEQ_LOAD),
		.startup_code (fuse_sync.startup_time),
		.done      (delay_done),
		.wake_req  (wake_req && core_reset_n),
		.wake_done (wake_done)
	);

	// Register port decode
	assign wr_trim  = bus.wr && core_reset_n && (bus.addr == scpc_pkg::ADDR_TRIM);
	assign wr_presc = bus.wr && core_reset_n && (bus.addr == scpc_pkg::ADDR_PRESC);
	assign wr_async = bus.wr && core_reset_n && (bus.addr == scpc_pkg::ADDR_ASYNC);

	assign pce_arm = wr_presc && (bus.wdata == scpc_pkg::PCE_ONLY);
	assign field_write    = wr_presc && prescale_change_enable && !bus.wdata[scpc_pkg::PCE_BIT];
	assign pce_open_write = pce_arm && prescale_change_enable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_oscillator_trim <= 8'h00;
		end else if (ce) begin
			if (seq == SEQ_LOAD) rc_oscillator_trim <= fuse_sync.factory_trim;
			else if (wr_trim) rc_oscillator_trim <= bus.wdata;
		end
	end

	assign trim_range_bit  = rc_oscillator_trim[scpc_pkg::TRIM_TOP_BIT];
	assign trim_fine_field = rc_oscillator_trim[6:0];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_select_field <= scpc_pkg::DIV_RESET_DIV8;
		end else if (ce) begin
			if (seq == SEQ_LOAD) begin
				prescale_select_field <= fuse_sync.divide_by_eight ?
					scpc_pkg::DIV_RESET_DIV8 : scpc_pkg::DIV_RESET_PLAIN;
			end else if (field_write) begin
				prescale_select_field <= bus.wdata[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_change_enable <= 1'b0;
			pce_count              <= 3'h0;
		end else if (ce) begin
			if (field_write) begin
				prescale_change_enable <= 1'b0;
				pce_count              <= 3'h0;
			end else if (prescale_change_enable) begin
				pce_count <= 3'(pce_count - 3'h1);
				if (pce_count == 3'h1) prescale_change_enable <= 1'b0;
			end else if (pce_arm) begin
				prescale_change_enable <= 1'b1;
				pce_count              <= scpc_pkg::PCE_WINDOW;
			end
		end
	end

	// Timer oscillator control bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			async_timer_status_reg <= 8'h00;
		end else if (ce && wr_async) begin
			async_timer_status_reg <= bus.wdata & scpc_pkg::ASYNC_MASK;
		end
	end

	// Read data, valid in the cycle after the read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (ce && bus.rd) begin
			unique case (bus.addr)
				scpc_pkg::ADDR_TRIM:  rdata <= rc_oscillator_trim;
				scpc_pkg::ADDR_PRESC: rdata <= {prescale_change_enable, 3'h0,
					prescale_select_field};
				scpc_pkg::ADDR_ASYNC: rdata <= async_timer_status_reg;
				default:              rdata <= 8'h00;
			endcase
		end
	end

	scpc_prescaler u_prescaler (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (ce),
		.code        (prescale_select_field),
		.tick        (div_tick),
		.clk_level   (div_level),
		.active_code (div_active)
	);

	assign sys_clk_enable = div_tick && ce;

	assign clock_output_pin_oe = fuse_sync.clock_output || port_oe;
	assign clock_output_pin    = fuse_sync.clock_output ? div_level : port_out;

	assign sys_source_external = (fuse_sync.source_select == scpc_pkg::SRC_EXTERNAL);

	assign rc_selected = (fuse_sync.source_select == scpc_pkg::SRC_RC) ||
		(fuse_sync.source_select == scpc_pkg::SRC_RC_LOW);
	assign timer_osc_ext_clock_accept = rc_selected &&
		async_timer_status_reg[scpc_pkg::ASYNC_EN_BIT] &&
		async_timer_status_reg[scpc_pkg::EXT_CLOCK_BIT];
	assign timer_osc_crystal_enable = rc_selected &&
		async_timer_status_reg[scpc_pkg::ASYNC_EN_BIT] &&
		!async_timer_status_reg[scpc_pkg::EXT_CLOCK_BIT];

	// Register and window checks
	// lone enable arms
	pce_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && wr_presc && !prescale_change_enable && bus.wdata != scpc_pkg::PCE_ONLY
		|=> !prescale_change_enable) else $error("enable set by mixed write");
	pce_timeout_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		$rose(prescale_change_enable) && !bus.wr |-> prescale_change_enable [*4] ##1
		!prescale_change_enable) else $error("enable window not four cycles");
	pce_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		prescale_change_enable |-> pce_count inside {[3'h1:3'h4]})
		else $error("enable window counter out of range");
	pce_rewrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && pce_open_write |=> pce_count == 3'($past(pce_count) - 3'h1))
		else $error("enable rewrite restarted window");
	pce_mixed_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && wr_presc && prescale_change_enable && bus.wdata[scpc_pkg::PCE_BIT]
		|=> $stable(prescale_select_field)) else $error("division written with enable bit");
	field_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && field_write |=> prescale_select_field == $past(bus.wdata[3:0]) &&
		!prescale_change_enable) else $error("division write not taken");
	field_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && seq == SEQ_RUN && !prescale_change_enable |=> $stable(prescale_select_field))
		else $error("division changed without enable");
	reset_div_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && seq == SEQ_LOAD |=> prescale_select_field ==
		($past(fuse_sync.divide_by_eight) ? 4'h3 : 4'h0)) else $error("reset division wrong");
	reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && bus.rd && bus.addr == scpc_pkg::ADDR_PRESC |=> rdata[6:4] == 3'h0)
		else $error("reserved prescale bits not zero");
	unit_div_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		div_tick && div_active == 4'h0 && prescale_select_field == 4'h0 |=> div_tick)
		else $error("undivided clock skipped a cycle");
	enable_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		sys_clk_enable |-> ce && div_tick)
		else $error("divided enable without clock enable");

	// Trim, pin and oscillator checks
	// factory trim loaded
	trim_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && seq == SEQ_LOAD |=> rc_oscillator_trim == $past(fuse_sync.factory_trim))
		else $error("factory trim not loaded");
	trim_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && wr_trim |=> rc_oscillator_trim == $past(bus.wdata))
		else $error("trim write not taken");
	write_block_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && !core_reset_n && seq != SEQ_LOAD |=> $stable(rc_oscillator_trim))
		else $error("trim changed while core held");
	trim_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && bus.rd && bus.addr == scpc_pkg::ADDR_TRIM
		|=> rdata == $past(rc_oscillator_trim))
		else $error("trim read back wrong");
	pin_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		!fuse_sync.clock_output |-> clock_output_pin == port_out &&
		clock_output_pin_oe == port_oe) else $error("clock pin lost its port function");
	clock_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		fuse_sync.clock_output |-> clock_output_pin_oe && clock_output_pin == div_level)
		else $error("clock pin not driven with divided clock");
	timer_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
		timer_osc_ext_clock_accept || timer_osc_crystal_enable |-> rc_selected)
		else $error("timer oscillator used without RC source");
	async_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		(async_timer_status_reg & ~scpc_pkg::ASYNC_MASK) == 8'h00)
		else $error("unused timer control bits set");

	// Main scenarios
	clock_out_reset_c: cover property (@(posedge clk) disable iff (!rst_n)
		fuse_sync.clock_output && seq == SEQ_DELAY && clock_output_pin_oe);
	change_seq_c: cover property (@(posedge clk) disable iff (!rst_n)
		pce_arm && !prescale_change_enable ##[1:4] field_write);
	div8_reset_c: cover property (@(posedge clk) disable iff (!rst_n)
		seq == SEQ_LOAD && fuse_sync.divide_by_eight);
	pce_expire_c: cover property (@(posedge clk) disable iff (!rst_n)
		$fell(prescale_change_enable) && !field_write);
	div_switch_c: cover property (@(posedge clk) disable iff (!rst_n)
		div_tick && div_active != prescale_select_field);

endmodule : scpc_top

// ### design/scpc_pkg.sv
// Shared constants, carrier types and decode function of the clock prescale control block
package scpc_pkg;

	// Core clock rate
	localparam int CLK_MHZ = 50;

	// Register offsets on the plain register port
	localparam logic [3:0] ADDR_TRIM  = 4'h0;
	localparam logic [3:0] ADDR_PRESC = 4'h1;
	localparam logic [3:0] ADDR_ASYNC = 4'h2;

	// Field positions and masks
	localparam int         PCE_BIT      = 7;
	localparam int         EXT_CLOCK_BIT = 6;
	localparam int         ASYNC_EN_BIT = 5;
	localparam int         TRIM_TOP_BIT = 7;
	localparam logic [7:0] PCE_ONLY     = 8'h80;
	localparam logic [7:0] ASYNC_MASK   = 8'h60;

	// Clock source select codes
	localparam logic [3:0] SRC_EXTERNAL = 4'h0;
	localparam logic [3:0] SRC_RC       = 4'h2;
	localparam logic [3:0] SRC_RC_LOW   = 4'h3;

	// Division field values
	localparam logic [3:0] DIV_RESET_PLAIN = 4'h0;
	localparam logic [3:0] DIV_RESET_DIV8  = 4'h3;
	localparam logic [3:0] DIV_MAX_CODE    = 4'h8;

	// Change enable window in core cycles
	localparam logic [2:0] PCE_WINDOW = 3'h4;

	// Start-up time codes
	localparam logic [1:0] STARTUP_SHORT = 2'h0;
	localparam logic [1:0] STARTUP_FAST  = 2'h1;
	localparam logic [1:0] STARTUP_SLOW  = 2'h2;

	// Start-up delays: cycle counts and times in microseconds
	localparam int WAKE_CK      = 6;
	localparam int RESET_CK     = 14;
	localparam int FAST_US      = 4100;
	localparam int SLOW_US      = 65000;
	localparam int FAST_CYCLES  = FAST_US * CLK_MHZ;
	localparam int SLOW_CYCLES  = SLOW_US * CLK_MHZ;
	localparam logic [1:0] SYNC_WAIT = 2'h2;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} scpc_bus_type;

	// Fuses and factory calibration byte
	typedef struct packed {
		logic [3:0] source_select;
		logic [1:0] startup_time;
		logic       clock_output;
		logic       divide_by_eight;
		logic [7:0] factory_trim;
	} scpc_fuse_type;

	// Division factor minus one; reserved codes run as the largest factor
	function automatic logic [7:0] div_mask(input logic [3:0] code);
		logic [8:0] factor;
		factor = 9'h001 << code;
		if (code > DIV_MAX_CODE) factor = 9'h100;
		div_mask = 8'(factor - 9'h001);
	endfunction : div_mask

endpackage : scpc_pkg

// ### design/scpc_prescaler.sv
// Glitch-free system clock prescaler driven by the undivided clock
`timescale 1ns/1ps
module scpc_prescaler (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Requested division code
	input  wire logic [3:0] code,
	// Divided clock
	output logic            tick,
	output logic            clk_level,
	output logic [3:0]      active_code
);
	logic [7:0] count;
	logic [7:0] mask;
	logic [7:0] next_count;
	logic [7:0] next_mask;

	// One tick per divided period
	// factor from code
	assign mask = scpc_pkg::div_mask(active_code);
	assign tick = (count == mask);

	// Values after this edge; a new code is taken only at a period end
	// old tick then new period
	always_comb begin
		next_count = tick ? 8'h00 : 8'(count + 8'h01);
		next_mask  = tick ? scpc_pkg::div_mask(code) : mask;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count       <= 8'h00;
			active_code <= scpc_pkg::DIV_RESET_DIV8;
		end else if (ce) begin
			count <= next_count;
			if (tick) active_code <= code;
		end
	end

	// Divided clock level, high over the first half of each period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_level <= 1'b1;
		end else if (ce) begin
			clk_level <= (next_mask == 8'h00) || (next_count <= (next_mask >> 1));
		end
	end

	count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		count <= mask) else $error("prescaler count beyond period");
	new_code_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		tick && code != active_code |=> active_code == $past(code) && count == 8'h00)
		else $error("new division not taken at period end");
	div_four_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		tick && code == 4'h2 && active_code == 4'h2 |=> !tick [*3] ##1 tick)
		else $error("divide by four period wrong");

endmodule : scpc_prescaler

// ### design/scpc_startup.sv
// Reset and wake-up delay counters counted in source clock cycles
`timescale 1ns/1ps
module scpc_startup #(
	parameter int FAST_CYCLES = scpc_pkg::FAST_CYCLES,
	parameter int SLOW_CYCLES = scpc_pkg::SLOW_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Reset delay
	input  wire logic       start,
	input  wire logic [1:0] startup_code,
	output logic            done,
	// Wake-up delay
	input  wire logic       wake_req,
	output logic            wake_done
);
	logic [21:0] count;
	logic        busy;
	logic [2:0]  wake_count;
	logic        wake_busy;
	logic [21:0] delay;

	always_comb begin
		unique case (startup_code)
			scpc_pkg::STARTUP_SHORT: delay = 22'(scpc_pkg::RESET_CK);
			scpc_pkg::STARTUP_FAST:  delay = 22'(scpc_pkg::RESET_CK + FAST_CYCLES);
			default:            delay = 22'(scpc_pkg::RESET_CK + SLOW_CYCLES);
		endcase
	end

	assign done      = busy && (count == 22'h000000);
	assign wake_done = wake_busy && (wake_count == 3'h0);

	// Reset delay counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 22'h000000;
			busy  <= 1'b0;
		end else if (ce) begin
			if (start) begin
				count <= 22'(delay - 22'h000001);
				busy  <= 1'b1;
			end else if (done) begin
				busy <= 1'b0;
			end else if (busy) begin
				count <= 22'(count - 22'h000001);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_count <= 3'h0;
			wake_busy  <= 1'b0;
		end else if (ce) begin
			if (wake_req && !wake_busy) begin
				wake_count <= 3'(scpc_pkg::WAKE_CK - 1);
				wake_busy  <= 1'b1;
			end else if (wake_done) begin
				wake_busy <= 1'b0;
			end else if (wake_busy) begin
				wake_count <= 3'(wake_count - 3'h1);
			end
		end
	end

	reset_delay_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		start && startup_code == scpc_pkg::STARTUP_SHORT |-> !done [*8] ##7 done)
		else $error("short reset delay not 14 cycles");
	wake_delay_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		wake_req && !wake_busy |-> !wake_done [*6] ##0 1'b1 ##0 !wake_done ##0 1'b1)
		else $error("wake-up delay too short");
	wake_end_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		wake_req && !wake_busy |-> ##6 wake_done)
		else $error("wake-up delay not six cycles");

endmodule : scpc_startup

// ### bench/scpc_clock_load.sv
// Model of a circuit clocked from the clock output pin, measuring its period
`timescale 1ns/1ps
module scpc_clock_load (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Clock output pin and its enable
	input  wire logic pin,
	input  wire logic pin_oe,
	// Last period seen, in core cycles
	output int        period
);
	int   count;
	logic last;
	// Undriven pin reads as the inverse of its last level
	logic level;
	assign level = pin_oe ? pin : ~last;
	// Count core cycles between rising levels of the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count  <= 0;
			last   <= 1'b0;
			period <= 0;
		end else begin
			last  <= level;
			count <= count + 1;
			if (level && !last) begin
				period <= count;
				count  <= 1;
			end
		end
	end
endmodule : scpc_clock_load

// ### bench/scpc_top_bench.sv
// Self-checking bench of the clock prescale control block
`timescale 1ns/1ps
module scpc_top_bench;
	logic                   clk;
	logic                   rst_n;
	logic                   ce;
	scpc_pkg::scpc_fuse_type fuses;
	scpc_pkg::scpc_bus_type  bus;
	logic [7:0]             rdata;
	logic                   wake_req;
	logic                   wake_done;
	logic                   core_reset_n;
	logic                   sys_clk_enable;
	logic                   port_out;
	logic                   port_oe;
	logic                   pin;
	logic                   pin_oe;
	logic                   src_ext;
	logic                   xtal_en;
	logic                   ext_acc;
	logic                   range_bit;
	logic [6:0]             fine;
	int                     period;
	int                     err_count;
	int                     checked;
	int                     n0;
	int                     n1;
	logic [7:0]             v;
	// Design with short start-up delays
	scpc_top #(.FAST_CYCLES(10), .SLOW_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.fuses(fuses), .bus(bus), .rdata(rdata), .wake_req(wake_req), .wake_done(wake_done),
		.core_reset_n(core_reset_n), .sys_clk_enable(sys_clk_enable), .port_out(port_out),
		.port_oe(port_oe), .clock_output_pin(pin), .clock_output_pin_oe(pin_oe),
		.sys_source_external(src_ext), .timer_osc_crystal_enable(xtal_en),
		.timer_osc_ext_clock_accept(ext_acc), .trim_range_bit(range_bit),
		.trim_fine_field(fine));
	// Circuit fed from the clock output pin
	scpc_clock_load load (.clk(clk), .rst_n(rst_n), .pin(pin), .pin_oe(pin_oe), .period(period));
	// 50 MHz core clock
	// steady frequency throughout
	initial clk = 1'b0;
	always #10 clk = ~clk;
	// Compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %0h seen %0h", name, exp, got);
			err_count++;
		end
	endtask : chk
	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	// One register port cycle
	task automatic cyc(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
		@(posedge clk);
		bus <= {a, d, w, r};
	endtask : cyc
	// Read one register; data stand in the following cycle
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		cyc(a, 8'h00, 1'b0, 1'b1);
		cyc(4'h0, 8'h00, 1'b0, 1'b0);
		#1 d = rdata;
	endtask : rd
	// Reset with given fuses, returns cycles until the core leaves reset
	task automatic rst(input logic [3:0] src, input logic [1:0] start_code, input logic clk_out,
		input logic d8, output int n);
		@(posedge clk);
		rst_n <= 1'b0;
		fuses <= {src, start_code, clk_out, d8, 8'hA5};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (core_reset_n !== 1'b1 && n < 200);
	endtask : rst
	// Timed change sequence
	task automatic setdiv(input logic [3:0] code);
		cyc(4'h1, 8'h80, 1'b1, 1'b0);
		cyc(4'h1, {4'h0, code}, 1'b1, 1'b0);
		cyc(4'h0, 8'h00, 1'b0, 1'b0);
	endtask : setdiv
	// Cycles between two divided clock pulses
	task automatic meas(output int p);
		int i;
		i = 0;
		p = 0;
		do begin
			@(posedge clk);
			i++;
		end while (sys_clk_enable !== 1'b1 && i < 600);
		do begin
			@(posedge clk);
			p++;
		end while (sys_clk_enable !== 1'b1 && p < 600);
	endtask : meas
	// Reset values, start-up delays and wake-up delay
	task automatic t_reset;
		int p;
		int k;
		rst(4'h0, 2'h0, 1'b1, 1'b1, n0);
		rd(4'h0, v);
		chk("trim", 8'hA5, v);
		rd(4'h1, v);
		chk("presc div8", 8'h03, v);
		chk("ext src", 1'b1, src_ext);
		chk("xtal", 1'b0, xtal_en);
		meas(p);
		chk("div8 period", 8, p);
		meas(p);
		chk("pin period", 8, period);
		chk("pin oe", 1'b1, pin_oe);
		@(posedge clk) wake_req <= 1'b1;
		@(posedge clk) wake_req <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wake_done !== 1'b1 && k < 20);
		chk("wake", 6, k);
		rst(4'h0, 2'h1, 1'b1, 1'b0, n1);
		chk("fast delay", 10, n1 - n0);
		rd(4'h1, v);
		chk("presc plain", 8'h00, v);
		rst(4'h0, 2'h2, 1'b1, 1'b0, n1);
		chk("slow delay", 20, n1 - n0);
	endtask : t_reset
	// Change sequence, divided periods and switch timing
	task automatic t_change;
		int p;
		int k;
		int t;
		int last;
		setdiv(4'h5);
		rd(4'h1, v);
		chk("field 5", 8'h05, v);
		meas(p);
		chk("period 32", 32, p);
		meas(p);
		chk("pin 32", 32, period);
		setdiv(4'h1);
		k = 0;
		t = 0;
		last = 0;
		while (t < 2 && k < 100) begin
			@(posedge clk);
			k++;
			if (sys_clk_enable === 1'b1) begin
				t++;
				if (t == 2) chk("short gap", 1'b1, (k - last) >= 2);
				last = k;
			end
		end
		chk("switch time", 1'b1, k <= 37);
		meas(p);
		chk("period 2", 2, p);
		setdiv(4'hA);
		rd(4'h1, v);
		chk("reserved code", 8'h0A, v);
		cyc(4'h1, 8'h85, 1'b1, 1'b0);
		cyc(4'h1, 8'h07, 1'b1, 1'b0);
		rd(4'h1, v);
		chk("no arm", 8'h0A, v);
		cyc(4'h1, 8'h80, 1'b1, 1'b0);
		cyc(4'h0, 8'h00, 1'b0, 1'b0);
		cyc(4'h1, 8'h80, 1'b1, 1'b0);
		rd(4'h1, v);
		chk("enable kept", 8'h8A, v);
		cyc(4'h1, 8'h02, 1'b1, 1'b0);
		rd(4'h1, v);
		chk("no restart", 8'h0A, v);
		setdiv(4'h7);
		cyc(4'h1, 8'h70, 1'b1, 1'b0);
		cyc(4'h1, 8'h80, 1'b1, 1'b0);
		cyc(4'h1, 8'h72, 1'b1, 1'b0);
		rd(4'h1, v);
		chk("upper bits", 8'h02, v);
	endtask : t_change
	// Trim register, unmapped place and oscillator steering
	task automatic t_regs;
		cyc(4'h0, 8'h7F, 1'b1, 1'b0);
		cyc(4'h2, 8'h60, 1'b1, 1'b0);
		rd(4'h0, v);
		chk("trim back", 8'h7F, v);
		chk("range low", 1'b0, range_bit);
		chk("fine max", 7'h7F, fine);
		chk("no acc ext", 1'b0, ext_acc);
		cyc(4'h0, 8'h80, 1'b1, 1'b0);
		rd(4'h5, v);
		chk("unmapped", 8'h00, v);
		chk("range high", 1'b1, range_bit);
		chk("fine min", 7'h00, fine);
		@(posedge clk);
		port_out <= 1'b1;
		port_oe <= 1'b0;
		rst(4'h2, 2'h0, 1'b0, 1'b0, n1);
		chk("port oe", 1'b0, pin_oe);
		chk("port pin", 1'b1, pin);
		chk("rc src", 1'b0, src_ext);
		cyc(4'h2, 8'h60, 1'b1, 1'b0);
		rd(4'h2, v);
		chk("async reg", 8'h60, v);
		chk("acc ext", 1'b1, ext_acc);
		cyc(4'h2, 8'h20, 1'b1, 1'b0);
		rd(4'h2, v);
		chk("xtal on", 1'b1, xtal_en);
		chk("acc off", 1'b0, ext_acc);
	endtask : t_regs
	// Main sequence
	initial begin
		err_count = 0;
		checked = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		fuses = '0;
		bus = '0;
		wake_req = 1'b0;
		port_out = 1'b0;
		port_oe = 1'b1;
		t_reset();
		t_change();
		t_regs();
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#400000;
		err_count++;
		test_done();
	end
endmodule : scpc_top_bench
